/* dv/sbst_host.sv */
// Purpose: Behavioural test-port controller that drives the link pins.
// Assumes: Each test-clock period spans about nine core clock cycles.
// Notes: An undriven input toggles, so a stale level is never mistaken.
`timescale 1ns/1ps
module sbst_host (
    input wire logic core_clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i,
    output logic tck_o,
    output logic tms_o,
    output logic tms_drv_o,
    output logic tdi_o,
    output logic tdi_drv_o
);
    // ----------------------------------------------------------------
    // Link pin driving
    // ----------------------------------------------------------------
    // The clock stands still between calls, as a real controller idles.
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tms_drv_o = 1'b1;
        tdi_o = 1'b1;
        tdi_drv_o = 1'b1;
    end

    // Inputs move while the clock is low, so they are settled at the rise.
    task automatic step(input logic m, input logic d, input logic md,
                        input logic dd, output logic o, output logic oen);
        @(posedge core_clk_i);
        #1;
        tck_o = 1'b0;
        tms_drv_o = md;
        tdi_drv_o = dd;
        tms_o = md ? m : ~tms_o;
        tdi_o = dd ? d : ~tdi_o;
        repeat (4) @(posedge core_clk_i);
        #1;
        tck_o = 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
        o = tdo_i;
        oen = tdo_oe_n_i;
    endtask

    // Five high mode-select periods bring the port back to reset.
    task automatic reset_seq(input logic md);
        logic o;
        logic oen;
        repeat (5) step(1'b1, 1'b1, md, 1'b1, o, oen);
    endtask
endmodule

/* dv/test_sram_boundary_scan_tap.sv */
// Purpose: Self-checking bench for the memory boundary-scan test port.
// Assumes: Boundary chain shifts pins_i bit 0 first, pad ones last.
// Notes: A queue models the pin FIFO; every scan result is predicted.
`timescale 1ns/1ps
module test_sram_boundary_scan_tap;
    import sbst_pkg::*;
    // ----------------------------------------------------------------
    // Signals and models
    // ----------------------------------------------------------------
    // Arbitrary identification value; bit 0 is set as the chain needs.
    localparam logic [31:0] ID_V = 32'h5A3C_0F1B;
    logic core_clk_i, rst_i, tck_i, tms_i, tms_drv_i, tdi_i, tdi_drv_i;
    logic tdo_o, tdo_oe_n_o, pins_valid_i, pins_ready_o;
    logic mem_out_float_o, extest_o;
    logic [7:0] pins_i, bsr_update_o;
    logic [7:0] q[$];
    logic [2:0] ir_m, code;
    logic [9:0] cap;
    logic [63:0] din, got, exp;
    logic tdi_en = 1'b1;
    logic bnd;
    int error_cnt = 0;
    int num_checks = 0;

    // The clock toggles every half period of 10 ns.
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    sbst_tap #(.PIN_W(8), .PAD_W(2), .ID_VALUE(ID_V)) DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .tck_i(tck_i),
        .tms_i(tms_i), .tms_drv_i(tms_drv_i), .tdi_i(tdi_i),
        .tdi_drv_i(tdi_drv_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
        .pins_i(pins_i), .pins_valid_i(pins_valid_i),
        .pins_ready_o(pins_ready_o), .mem_out_float_o(mem_out_float_o),
        .bsr_update_o(bsr_update_o), .extest_o(extest_o));

    sbst_host host (
        .core_clk_i(core_clk_i), .tdo_i(tdo_o), .tdo_oe_n_i(tdo_oe_n_o),
        .tck_o(tck_i), .tms_o(tms_i), .tms_drv_o(tms_drv_i),
        .tdi_o(tdi_i), .tdi_drv_o(tdi_drv_i));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tb(input logic m, input logic d, output logic o,
                      output logic e);
        host.step(m, d, 1'b1, tdi_en, o, e);
    endtask

    // Walks the controller with a mode-select list, bit 0 first.
    task automatic moves(input logic [7:0] seq, input int n);
        logic o, e;
        for (int i = 0; i < n; i++) tb(seq[i], 1'b1, o, e);
    endtask

    task automatic ir_scan(input logic [2:0] c);
        logic o, e;
        logic [2:0] g;
        moves(8'h03, 4);
        for (int k = 0; k < 3; k++) begin
            tb(k == 2, c[k], o, e);
            g[k] = o;
        end
        chk(g, {ir_m[2], SBST_IR_CAPTURE});
        moves(8'h01, 2);
        ir_m = c;
    endtask

    task automatic dr_scan(input int n, input logic [63:0] d);
        logic o, e;
        got = '0;
        moves(8'h01, 3);
        for (int k = 0; k < n; k++) begin
            tb(k == n - 1, d[k], o, e);
            got[k] = o;
            if (k == 0) chk(e, 1'b0);
        end
        moves(8'h01, 2);
        chk(tdo_oe_n_o, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    // A hang is cut short long after the expected run time.
    initial begin
        #1000000;
        error_cnt++;
        $display("FAIL t=%0t got=%h exp=%h", $time, 0, 1);
        give_verdict();
    end

    initial begin
        rst_i = 1'b1;
        pins_i = 8'h00;
        pins_valid_i = 1'b0;
        void'($urandom(32'hB5DECDEA));
        repeat (2) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        repeat (20) @(posedge core_clk_i);
        chk({tdo_oe_n_o, tdo_o, mem_out_float_o, extest_o, bsr_update_o,
             pins_ready_o}, 13'h1801);
        $display("test power_up done");
        ir_m = SBST_INS_IDCODE;
        host.reset_seq(1'b0);
        moves(8'h00, 1);
        dr_scan(32, {$urandom, $urandom});
        chk(got, {32'h0, ID_V});
        $display("test idcode done");
        // Fill the pin FIFO until it refuses a ninth word.
        @(posedge core_clk_i);
        #1;
        pins_valid_i = 1'b1;
        for (int i = 0; i < 9; i++) begin
            pins_i = 8'($urandom);
            if (pins_ready_o === 1'b1) q.push_back(pins_i);
            @(posedge core_clk_i);
            #1;
        end
        pins_valid_i = 1'b0;
        chk({pins_ready_o, 4'(q.size())}, 5'h08);
        // Every code once, then preloads until the FIFO drains.
        for (int n = 0; n < 13; n++) begin
            code = (n < 8) ? 3'(n) : SBST_INS_PRELOAD;
            ir_scan(code);
            chk(mem_out_float_o, code == SBST_INS_SAMPZ);
            chk(extest_o, code == SBST_INS_EXTEST);
            din = {$urandom, $urandom};
            bnd = (code == 3'h0 || code == 3'h2 || code == 3'h4);
            if (bnd) cap = {2'b11, q.pop_front()};
            exp = bnd ? {54'h0, cap} : (code == 3'h1) ? {32'h0, ID_V} :
                  ({din[62:0], 1'b0} & 64'h3FF);
            dr_scan(code == 3'h1 ? 32 : 10, din);
            chk(got, exp);
            if (bnd) chk(bsr_update_o, din[7:0]);
        end
        chk(pins_ready_o, 1'b1);
        $display("test codes done");
        ir_scan(SBST_INS_BYPASS);
        tdi_en = 1'b0;
        dr_scan(10, 64'h0);
        tdi_en = 1'b1;
        chk(got, 64'h3FE);
        $display("test float_tdi done");
        moves(8'h01, 3);
        moves(8'h00, 4);
        host.reset_seq(1'b1);
        moves(8'h00, 1);
        ir_m = SBST_INS_IDCODE;
        dr_scan(32, {$urandom, $urandom});
        chk(got, {32'h0, ID_V});
        $display("test mid_reset done");
        give_verdict();
    end
endmodule

/* logic/sbst_fifo.sv */
// Purpose: Small flip-flop FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty come from a count, so both are exact.
`timescale 1ns/1ps
module sbst_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rd_ff];

    // Pointers and count move on accepted handshakes only.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage carries no reset; only valid entries are ever read.
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end
endmodule

/* logic/sbst_tap.sv */
// Purpose: Boundary-scan test access port of a synchronous memory.
// Assumes: Test clock is far slower than core_clk_i and is sampled.
// Notes: Captured boundary words queue in a FIFO toward the chain.
// Notes on behaviour
// - Sample inputs rising, drive output falling.
// - Floating mode-select reads as one.
// - Floating serial input reads as one.
// - Five high mode-select edges reach reset.
// - Self reset at power-up, idle until clocked.
// - Serial output enabled by controller state.
// - State and instruction pick connected register.
// - One register at a time, shift rising.
// - Three-bit instruction, loaded only when connected.
// - Instruction acts in idle and data states.
// - Reset presets identification instruction.
// - Single flip-flop bypass path.
// - Boundary chain captures pins, shifts toward output.
// - Unbonded chain cells capture one.
// - Three instructions select boundary chain.
// - Decode codes; reserved act as bypass.
// - Capture-IR loads 01 in low bits.
// - 32-bit identification, shifted LSB first.
// - Float-sample forces memory outputs off.
`timescale 1ns/1ps
module sbst_tap
    import sbst_pkg::*;
#(
    parameter int PIN_W = 8,
    parameter int PAD_W = 2,
    parameter logic [31:0] ID_VALUE = SBST_ID_DEFAULT
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tms_drv_i,
    input wire logic tdi_i,
    input wire logic tdi_drv_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    input wire logic [PIN_W-1:0] pins_i,
    input wire logic pins_valid_i,
    output logic pins_ready_o,
    output logic mem_out_float_o,
    output logic [PIN_W-1:0] bsr_update_o,
    output logic extest_o
);
    localparam int BS_W = PIN_W + PAD_W;
    typedef enum logic [3:0] {
        S_RESET, S_IDLE, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR,
        S_PAU_DR, S_EX2_DR, S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR,
        S_EX1_IR, S_PAU_IR, S_EX2_IR, S_UPD_IR
    } sbst_state_t;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Undriven mode-select and data read as one, like the pull-ups.
    wire tms_pin = tms_drv_i ? tms_i : 1'b1;
    wire tdi_pin = tdi_drv_i ? tdi_i : 1'b1;
    logic [2:0] tck_s_ff;
    logic [2:0] tms_s_ff;
    logic [2:0] tdi_s_ff;
    logic tck_lvl_ff;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tck_s_ff <= 3'h0;
            tms_s_ff <= 3'h7;
            tdi_s_ff <= 3'h7;
        end else begin
            tck_s_ff <= {tck_s_ff[1:0], tck_i};
            tms_s_ff <= {tms_s_ff[1:0], tms_pin};
            tdi_s_ff <= {tdi_s_ff[1:0], tdi_pin};
        end
    end
    // A change counts once stages two and three agree.
    wire tck_agree = (tck_s_ff[1] == tck_s_ff[2]);
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tck_lvl_ff <= 1'b0;
        end else if (tck_agree) begin
            tck_lvl_ff <= tck_s_ff[2];
        end
    end
    wire tck_rise = tck_agree & tck_s_ff[2] & ~tck_lvl_ff;
    wire tck_fall = tck_agree & ~tck_s_ff[2] & tck_lvl_ff;
    wire tms_s = tms_s_ff[2];
    wire tdi_s = tdi_s_ff[2];

    // ----------------------------------------------------------------
    // Controller
    // ----------------------------------------------------------------
    sbst_state_t state_ff;
    sbst_state_t nxt_state;
    // Standard next-state table; reset state holds while mode-select high.
    always_comb begin
        case (state_ff)
            S_RESET: nxt_state = tms_s ? S_RESET : S_IDLE;
            S_IDLE: nxt_state = tms_s ? S_SEL_DR : S_IDLE;
            S_SEL_DR: nxt_state = tms_s ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: nxt_state = tms_s ? S_EX1_DR : S_SH_DR;
            S_SH_DR: nxt_state = tms_s ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: nxt_state = tms_s ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: nxt_state = tms_s ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: nxt_state = tms_s ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: nxt_state = tms_s ? S_SEL_DR : S_IDLE;
            S_SEL_IR: nxt_state = tms_s ? S_RESET : S_CAP_IR;
            S_CAP_IR: nxt_state = tms_s ? S_EX1_IR : S_SH_IR;
            S_SH_IR: nxt_state = tms_s ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: nxt_state = tms_s ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: nxt_state = tms_s ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: nxt_state = tms_s ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: nxt_state = tms_s ? S_SEL_DR : S_IDLE;
            default: nxt_state = S_RESET;
        endcase
    end
    // Power-up reset parks the controller; it moves only on test clock.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_ff <= S_RESET;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    logic [2:0] ir_sh_ff;
    logic [2:0] ir_ff;
    // Reserved and private codes fall through to bypass.
    function automatic logic sel_bsr(input logic [2:0] ins);
        sel_bsr = (ins == SBST_INS_EXTEST) | (ins == SBST_INS_SAMPZ) |
                  (ins == SBST_INS_PRELOAD);
    endfunction
    wire ins_bsr = sel_bsr(ir_ff);
    wire ins_id = (ir_ff == SBST_INS_IDCODE);
    wire ins_byp = ~ins_bsr & ~ins_id;
    assign mem_out_float_o = (ir_ff == SBST_INS_SAMPZ);
    assign extest_o = (ir_ff == SBST_INS_EXTEST);

    // Shift stage loads only while connected; update commits it.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ir_sh_ff <= SBST_INS_IDCODE;
            ir_ff <= SBST_INS_IDCODE;
        end else if (tck_rise) begin
            case (state_ff)
                S_RESET: begin
                    ir_ff <= SBST_INS_IDCODE;
                end
                S_CAP_IR: begin
                    ir_sh_ff <= {ir_sh_ff[2], SBST_IR_CAPTURE};
                end
                S_SH_IR: begin
                    ir_sh_ff <= {tdi_s, ir_sh_ff[2:1]};
                end
                S_UPD_IR: begin
                    ir_ff <= ir_sh_ff;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Data registers
    // ----------------------------------------------------------------
    logic byp_ff;
    logic [SBST_ID_W-1:0] id_ff;
    logic [BS_W-1:0] bsr_ff;
    logic [PIN_W-1:0] pin_word;
    logic pin_pop;
    // FIFO outputs are declared ahead of the instance that drives them.
    logic pin_avail;
    logic [PIN_W-1:0] fifo_word;
    wire in_dr_cap = tck_rise & (state_ff == S_CAP_DR);
    wire in_dr_sh = tck_rise & (state_ff == S_SH_DR);
    // Pad cells sit at the top of the chain and always capture one.
    wire [BS_W-1:0] bsr_cap = {{PAD_W{1'b1}}, pin_word};
    assign pin_pop = in_dr_cap & ins_bsr;

    // Pin samples queue here; capture takes the oldest, and when none
    // has arrived the chain's present low bits, last shifted in, are reused.
    sbst_fifo #(
        .WIDTH(PIN_W),
        .DEPTH(SBST_FIFO_DEPTH)
    ) u_pin_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(pins_valid_i),
        .in_ready_o(pins_ready_o),
        .in_data_i(pins_i),
        .out_valid_o(pin_avail),
        .out_ready_i(pin_pop),
        .out_data_o(fifo_word)
    );
    // Reusing the chain's present low bits keeps scans going when the memory
    // side supplies no fresh sample in time.
    assign pin_word = pin_avail ? fifo_word : bsr_ff[PIN_W-1:0];

    // Only the register the instruction selects captures or shifts.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            byp_ff <= 1'b0;
            id_ff <= '0;
            bsr_ff <= '1;
        end else begin
            if (in_dr_cap & ins_byp) begin
                byp_ff <= 1'b0;
            end else if (in_dr_sh & ins_byp) begin
                byp_ff <= tdi_s;
            end
            if (in_dr_cap & ins_id) begin
                id_ff <= ID_VALUE;
            end else if (in_dr_sh & ins_id) begin
                id_ff <= {tdi_s, id_ff[SBST_ID_W-1:1]};
            end
            if (pin_pop) begin
                bsr_ff <= bsr_cap;
            end else if (in_dr_sh & ins_bsr) begin
                bsr_ff <= {tdi_s, bsr_ff[BS_W-1:1]};
            end
        end
    end
    // Boundary update latch loads on the falling edge in update-DR under all three chain instructions.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bsr_update_o <= '0;
        end else if (tck_fall & (state_ff == S_UPD_DR) & ins_bsr) begin
            bsr_update_o <= bsr_ff[PIN_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Serial output
    // ----------------------------------------------------------------
    wire in_sh_ir = (state_ff == S_SH_IR);
    wire in_sh_dr = (state_ff == S_SH_DR);
    wire dr_tail = ins_bsr ? bsr_ff[0] : (ins_id ? id_ff[0] : byp_ff);
    wire tdo_sel = in_sh_ir ? ir_sh_ff[0] : dr_tail;
    // Output and its enable only change on the falling test edge.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tdo_o <= 1'b1;
            tdo_oe_n_o <= 1'b1;
        end else if (tck_fall) begin
            tdo_o <= tdo_sel;
            tdo_oe_n_o <= ~(in_sh_ir | in_sh_dr);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [2:0] hi_cnt_ff;
    always_ff @(posedge core_clk_i) begin
        if (rst_i | (tck_rise & ~tms_s)) begin
            hi_cnt_ff <= 3'h0;
        end else if (tck_rise & (hi_cnt_ff != 3'h7)) begin
            hi_cnt_ff <= hi_cnt_ff + 3'h1;
        end
    end
    sequence s_upd_ir;
        tck_rise && state_ff == S_UPD_IR;
    endsequence
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // The counter saturates, so a long reset hold keeps the check live.
    tms_reset_a: assert property (
        hi_cnt_ff >= 3'h5 |-> state_ff == S_RESET)
        else $error("five high edges did not reach reset");
    ir_preset_a: assert property (
        state_ff == S_RESET && tck_rise |=> ir_ff == SBST_INS_IDCODE)
        else $error("reset did not preset identification");
    ir_update_a: assert property (
        s_upd_ir |=> ir_ff == $past(ir_sh_ff))
        else $error("instruction not committed on update");
    ir_capture_a: assert property (
        tck_rise && state_ff == S_CAP_IR |=> ir_sh_ff[1:0] == 2'h1)
        else $error("capture pattern wrong");
    tdo_float_a: assert property (
        tck_fall && !in_sh_ir && !in_sh_dr |=> tdo_oe_n_o)
        else $error("serial output driven outside shift");
    tdo_falls_a: assert property (
        !tck_fall |=> $stable(tdo_o) && $stable(tdo_oe_n_o))
        else $error("serial output moved off falling edge");
    float_out_a: assert property (
        ir_ff == SBST_INS_SAMPZ |-> mem_out_float_o)
        else $error("outputs not floated");
    id_cap_a: assert property (
        in_dr_cap && ins_id |=> id_ff == ID_VALUE)
        else $error("identification not captured");
    pad_one_a: assert property (
        pin_pop |=> bsr_ff[BS_W-1:PIN_W] == '1)
        else $error("pad cells not one");
    byp_shift_a: assert property (
        in_dr_sh && ins_byp |=> byp_ff == $past(tdi_s))
        else $error("bypass did not take input");
endmodule

/* pkg/sbst_pkg.sv */
// Purpose: Shared constants for the memory boundary-scan test port.
// Assumes: 3-bit instructions, MSB first as written.
// Notes: Identification value is arbitrary and neutral.
package sbst_pkg;
    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SBST_INS_EXTEST = 3'h0;
    localparam logic [2:0] SBST_INS_IDCODE = 3'h1;
    localparam logic [2:0] SBST_INS_SAMPZ = 3'h2;
    localparam logic [2:0] SBST_INS_RSV_A = 3'h3;
    localparam logic [2:0] SBST_INS_PRELOAD = 3'h4;
    localparam logic [2:0] SBST_INS_PRIVATE = 3'h5;
    localparam logic [2:0] SBST_INS_RSV_B = 3'h6;
    localparam logic [2:0] SBST_INS_BYPASS = 3'h7;
    // ----------------------------------------------------------------
    // Widths and fixed patterns
    // ----------------------------------------------------------------
    localparam int SBST_IR_W = 3;
    localparam int SBST_ID_W = 32;
    localparam logic [1:0] SBST_IR_CAPTURE = 2'h1;
    // Arbitrary identification value, bit 0 set as the chain requires.
    localparam logic [31:0] SBST_ID_DEFAULT = 32'h0000_0ACF;
    localparam int SBST_RESET_TMS_EDGES = 5;
    localparam int SBST_FIFO_DEPTH = 8;
endpackage
